// >>> hw/two_wire_pkg.sv
// Purpose: Shared constants and types for both ends of the two-wire link.
// Assumes: ref_clk at 125 MHz; open-drain lines resolved in the carrier.
// Notes: Timing counts are derived from times in nanoseconds.
package two_wire_pkg;
	// -----------------------------------------------------------------
	// Packet layout
	// -----------------------------------------------------------------
	localparam int ADDR_BITS = 7;
	localparam int PACKET_BITS = 9;
	localparam logic [3:0] LAST_BIT = 4'h8;
	localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
	localparam logic [3:0] RESERVED_PREFIX = 4'hf;
	localparam logic [7:0] GC_READ_BYTE = 8'h01;
	localparam logic [7:0] IDLE_BYTE = 8'hff;

	// -----------------------------------------------------------------
	// Timing
	// -----------------------------------------------------------------
	localparam int REF_CLK_MHZ = 125;
	localparam int SCL_HALF_NS = 1250;
	localparam int SCL_HALF_CYC = (SCL_HALF_NS * REF_CLK_MHZ + 999) / 1000;
	localparam logic [7:0] HALF_LAST = 8'(SCL_HALF_CYC - 1);
	localparam logic [7:0] HALF_MID = 8'(SCL_HALF_CYC / 2);

	// -----------------------------------------------------------------
	// Host command set
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		CMD_START,
		CMD_STOP,
		CMD_WRITE,
		CMD_READ
	} cmd_t;
endpackage

// >>> hw/two_wire_link_if.sv
// Purpose: Carrier joining the bus master end and the device end.
// Assumes: Both lines have pull-ups; any enable pulls the line low.
// Notes: The wired-AND is worked out here, not in the ends.
`timescale 1ns/100ps
interface two_wire_link_if;
	logic m_scl_oe;
	logic m_sda_oe;
	logic s_scl_oe;
	logic s_sda_oe;
	logic scl;
	logic sda;

	// Open-drain lines: low whenever any party drives.
	assign scl = ~(m_scl_oe | s_scl_oe);
	assign sda = ~(m_sda_oe | s_sda_oe);

	modport master (output m_scl_oe, output m_sda_oe, input scl, input sda);
	modport slave (output s_scl_oe, output s_sda_oe, input scl, input sda);
endinterface

// >>> hw/two_wire_bus_master.sv
// Purpose: Bus master end: makes the clock, framing and byte transfers.
// Assumes: Commands arrive on ref_clk; the bus clock is divided from it.
// Notes: Arbitration is not handled; illegal commands are dropped with err.
`timescale 1ns/100ps
module two_wire_bus_master (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Command port
	input wire logic cmd_valid,
	input wire two_wire_pkg::cmd_t cmd,
	input wire logic [7:0] wr_data,
	input wire logic ack_send,
	output logic cmd_ready,
	output logic done,
	output logic err,
	output logic [7:0] rd_data,
	output logic ack_rx,
	output logic bus_busy,
	// Link
	two_wire_link_if.master link
);
	typedef enum logic [3:0] {
		H_IDLE, H_HOLD, H_ST_LOW, H_ST_HIGH, H_ST_SDA,
		H_SP_LOW, H_SP_HIGH, H_SP_SDA, H_BIT_LOW, H_BIT_HIGH
	} hstate_t;

	hstate_t st_q;
	logic [7:0] tmr_q;
	logic [3:0] bit_q;
	logic [8:0] sh_q;
	logic [8:0] rx_q;
	logic scl_oe_q, sda_oe_q, fresh_q, busy_q, done_q, err_q, ack_q;
	logic [7:0] rd_q;
	logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;

	// -----------------------------------------------------------------
	// Line sampling and bus state
	// -----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			{scl_m, scl_s, scl_p, sda_m, sda_s, sda_p} <= 6'h3f;
		end else begin
			{scl_m, scl_s, scl_p} <= {link.scl, scl_m, scl_s};
			{sda_m, sda_s, sda_p} <= {link.sda, sda_m, sda_s};
		end
	end

	wire start_det = scl_s & scl_p & sda_p & ~sda_s;
	wire stop_det = scl_s & scl_p & ~sda_p & sda_s;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			busy_q <= 1'b0;
		end else if (start_det) begin
			busy_q <= 1'b1; // RULE3 RULE4
		end else if (stop_det) begin
			busy_q <= 1'b0; // RULE3
		end
	end

	// -----------------------------------------------------------------
	// Half-period timer
	// -----------------------------------------------------------------
	// High phases are timed only once the line is seen high, so a slave
	// holding the clock low lengthens the low phase instead.
	wire in_high = (st_q == H_ST_HIGH) | (st_q == H_SP_HIGH) | (st_q == H_BIT_HIGH);
	wire stall = in_high & ~scl_s; // RULE20
	wire parked = (st_q == H_IDLE) | (st_q == H_HOLD);
	wire tdone = ~parked & ~stall & (tmr_q == two_wire_pkg::HALF_LAST);
	wire tmid = tmr_q == two_wire_pkg::HALF_MID;
	wire take = cmd_valid & parked;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			tmr_q <= 8'h00;
		end else if (parked | stall | tdone) begin
			tmr_q <= 8'h00;
		end else begin
			tmr_q <= tmr_q + 8'h01;
		end
	end

	// -----------------------------------------------------------------
	// Framing sequencer
	// -----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= H_IDLE;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			fresh_q <= 1'b0;
			bit_q <= 4'h0;
			sh_q <= 9'h1ff;
			rx_q <= 9'h000;
			rd_q <= 8'h00;
			ack_q <= 1'b0;
			done_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			err_q <= 1'b0;
			case (st_q)
				H_IDLE: begin
					if (take) begin
						if (cmd == two_wire_pkg::CMD_START && !busy_q) begin
							st_q <= H_ST_HIGH; // RULE3 RULE18
						end else begin
							err_q <= 1'b1;
						end
					end
				end
				H_HOLD: begin
					if (take) begin
						case (cmd)
							two_wire_pkg::CMD_START: st_q <= H_ST_LOW; // RULE4
							two_wire_pkg::CMD_STOP: begin
								if (fresh_q) begin
									err_q <= 1'b1; // RULE19
								end else begin
									st_q <= H_SP_LOW;
								end
							end
							two_wire_pkg::CMD_WRITE: begin
								if (fresh_q && wr_data == two_wire_pkg::GC_READ_BYTE) begin
									err_q <= 1'b1; // RULE11
								end else begin
									sh_q <= {wr_data, 1'b1}; // RULE5 RULE6
									bit_q <= 4'h0;
									st_q <= H_BIT_LOW;
								end
							end
							default: begin
								if (fresh_q) begin
									err_q <= 1'b1;
								end else begin
									sh_q <= {two_wire_pkg::IDLE_BYTE, ~ack_send}; // RULE15 RULE16
									bit_q <= 4'h0;
									st_q <= H_BIT_LOW;
								end
							end
						endcase
					end
				end
				H_ST_LOW: begin
					if (tmid) begin
						sda_oe_q <= 1'b0;
					end
					if (tdone) begin
						scl_oe_q <= 1'b0;
						st_q <= H_ST_HIGH;
					end
				end
				H_ST_HIGH: begin
					if (tdone) begin
						sda_oe_q <= 1'b1; // RULE2
						st_q <= H_ST_SDA;
					end
				end
				H_ST_SDA: begin
					if (tdone) begin
						scl_oe_q <= 1'b1;
						fresh_q <= 1'b1;
						st_q <= H_HOLD;
					end
				end
				H_SP_LOW: begin
					if (tmid) begin
						sda_oe_q <= 1'b1;
					end
					if (tdone) begin
						scl_oe_q <= 1'b0;
						st_q <= H_SP_HIGH;
					end
				end
				H_SP_HIGH: begin
					if (tdone) begin
						sda_oe_q <= 1'b0; // RULE2
						st_q <= H_SP_SDA;
					end
				end
				H_SP_SDA: begin
					if (tdone) begin
						st_q <= H_IDLE;
					end
				end
				H_BIT_LOW: begin
					if (tmid) begin
						sda_oe_q <= ~sh_q[8]; // RULE1 RULE9 RULE17
					end
					if (tdone) begin
						scl_oe_q <= 1'b0; // RULE14
						st_q <= H_BIT_HIGH;
					end
				end
				H_BIT_HIGH: begin
					if (tmr_q == 8'h00 && scl_s) begin
						rx_q <= {rx_q[7:0], sda_s};
					end
					if (tdone) begin
						sh_q <= {sh_q[7:0], 1'b1};
						scl_oe_q <= 1'b1;
						if (bit_q == two_wire_pkg::LAST_BIT) begin
							rd_q <= rx_q[8:1];
							ack_q <= ~rx_q[0]; // RULE15
							done_q <= 1'b1;
							fresh_q <= 1'b0;
							st_q <= H_HOLD; // RULE13
						end else begin
							bit_q <= bit_q + 4'h1;
							st_q <= H_BIT_LOW;
						end
					end
				end
				default: st_q <= H_IDLE;
			endcase
		end
	end

	assign cmd_ready = parked;
	assign done = done_q;
	assign err = err_q;
	assign rd_data = rd_q;
	assign ack_rx = ack_q;
	assign bus_busy = busy_q;
	assign link.m_scl_oe = scl_oe_q;
	assign link.m_sda_oe = sda_oe_q;
endmodule

// >>> hw/two_wire_slave.sv
// Purpose: Device end: slave that detects framing, matches address, moves bytes.
// Assumes: link_clk runs free and much faster than the bus clock.
// Notes: Settings are quasi-static and cross as levels; bytes cross by toggle.
`timescale 1ns/100ps

// Contract
// RULE1: data changes only while clock low
// RULE2: start/stop are data edges, clock high
// RULE3: busy from start until stop
// RULE4: repeated start behaves like start
// RULE5: address packet: 7 address, direction, acknowledge
// RULE6: direction one reads, zero writes
// RULE7: acknowledge own address on ninth clock
// RULE8: unable slave leaves acknowledge released
// RULE9: bytes shift most significant bit first
// RULE10: general call with write acknowledged when enabled
// RULE11: no general call with read direction
// RULE12: addresses 1111xxx are reserved, never matched
// RULE13: data packet: eight bits plus acknowledge
// RULE14: master clocks, receiver acknowledges
// RULE15: released ninth bit means not acknowledged
// RULE16: receiver refuses final or unwanted byte
// RULE17: drivers only pull low
// RULE18: master begins, ends, and clocks
// RULE19: no start directly followed by stop
// RULE20: slave may stretch clock low phase
// RULE21: compare own and general call address
module two_wire_slave (
	// Clocks and reset
	input wire logic ref_clk,
	input wire logic link_clk,
	input wire logic rstn,
	// Settings
	input wire logic [6:0] own_addr,
	input wire logic gc_enable,
	input wire logic ack_enable,
	input wire logic [7:0] tx_data,
	input wire logic stretch,
	// Received bytes and bus status
	output logic [7:0] rx_data,
	output logic rx_gc,
	output logic rx_valid,
	output logic bus_busy,
	// Link
	two_wire_link_if.slave link
);
	typedef enum logic [2:0] {
		M_IDLE, M_ADDR, M_RX, M_TX, M_SKIP
	} mode_t;

	// -----------------------------------------------------------------
	// Link domain: line and setting synchronisers
	// -----------------------------------------------------------------
	logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
	logic [17:0] cfg_m, cfg_s;

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			{scl_m, scl_s, scl_p, sda_m, sda_s, sda_p} <= 6'h3f;
		end else begin
			{scl_m, scl_s, scl_p} <= {link.scl, scl_m, scl_s};
			{sda_m, sda_s, sda_p} <= {link.sda, sda_m, sda_s};
		end
	end

	// Settings must be held while a transfer runs; each bit is crossed
	// on its own, so a change mid-packet may be seen torn.
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_m <= 18'h0_0000;
			cfg_s <= 18'h0_0000;
		end else begin
			cfg_m <= {stretch, ack_enable, gc_enable, tx_data, own_addr};
			cfg_s <= cfg_m;
		end
	end

	wire [6:0] own_s = cfg_s[6:0];
	wire [7:0] tx_s = cfg_s[14:7];
	wire gc_en_s = cfg_s[15];
	wire ack_en_s = cfg_s[16];
	wire stretch_s = cfg_s[17];

	// -----------------------------------------------------------------
	// Link domain: framing detection and decode
	// -----------------------------------------------------------------
	wire scl_rise = scl_s & ~scl_p;
	wire scl_fall = ~scl_s & scl_p;
	wire start_det = scl_s & scl_p & sda_p & ~sda_s; // RULE2 RULE4
	wire stop_det = scl_s & scl_p & ~sda_p & sda_s; // RULE2

	mode_t mode_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q, tx_q, rx_q;
	logic sda_oe_q, scl_oe_q, first_q, mack_q, busy_q, gc_q, rx_gc_q, rx_tgl_q;

	wire [6:0] addr_in = sh_q[7:1];
	wire rw_in = sh_q[0];
	wire match_own = (addr_in == own_s) & (own_s[6:3] != two_wire_pkg::RESERVED_PREFIX); // RULE12 RULE21
	wire match_gc = gc_en_s & (addr_in == two_wire_pkg::GENERAL_CALL_ADDR) & ~rw_in; // RULE10 RULE11 RULE21
	wire accept = (match_own | match_gc) & ack_en_s;
	wire last_bit = cnt_q == two_wire_pkg::LAST_BIT;

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			busy_q <= 1'b0;
		end else if (start_det) begin
			busy_q <= 1'b1; // RULE3 RULE4
		end else if (stop_det) begin
			busy_q <= 1'b0; // RULE3
		end
	end

	// -----------------------------------------------------------------
	// Link domain: packet engine
	// -----------------------------------------------------------------
	// The data line is only ever changed on a seen falling clock edge,
	// so it is steady across each high phase.
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			mode_q <= M_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			rx_q <= 8'h00;
			sda_oe_q <= 1'b0;
			first_q <= 1'b0;
			mack_q <= 1'b1;
			gc_q <= 1'b0;
			rx_gc_q <= 1'b0;
			rx_tgl_q <= 1'b0;
		end else if (start_det) begin
			mode_q <= M_ADDR; // RULE4
			cnt_q <= 4'h0;
			sda_oe_q <= 1'b0;
		end else if (stop_det) begin
			mode_q <= M_IDLE;
			sda_oe_q <= 1'b0;
		end else begin
			if (scl_rise && mode_q != M_IDLE) begin
				if (last_bit) begin
					mack_q <= sda_s; // RULE15
					cnt_q <= 4'h0;
				end else begin
					sh_q <= {sh_q[6:0], sda_s}; // RULE9
					cnt_q <= cnt_q + 4'h1;
				end
			end
			if (scl_fall) begin
				case (mode_q)
					M_ADDR: begin
						if (last_bit) begin
							if (accept) begin
								sda_oe_q <= 1'b1; // RULE7 RULE17
								mode_q <= rw_in ? M_TX : M_RX; // RULE6
								gc_q <= match_gc;
								first_q <= 1'b1;
							end else begin
								mode_q <= M_SKIP; // RULE8
							end
						end
					end
					M_RX: begin
						if (cnt_q == 4'h0) begin
							sda_oe_q <= 1'b0; // RULE1
						end else if (last_bit) begin
							rx_q <= sh_q; // RULE13
							rx_gc_q <= gc_q;
							rx_tgl_q <= ~rx_tgl_q;
							sda_oe_q <= ack_en_s; // RULE15 RULE16
						end
					end
					M_TX: begin
						if (cnt_q == 4'h0) begin
							first_q <= 1'b0;
							if (first_q || !mack_q) begin
								tx_q <= {tx_s[6:0], 1'b0}; // RULE9
								sda_oe_q <= ~tx_s[7];
							end else begin
								sda_oe_q <= 1'b0; // RULE16
								mode_q <= M_SKIP;
							end
						end else if (last_bit) begin
							sda_oe_q <= 1'b0; // RULE14
						end else begin
							sda_oe_q <= ~tx_q[7]; // RULE1 RULE17
							tx_q <= {tx_q[6:0], 1'b0};
						end
					end
					default: sda_oe_q <= 1'b0;
				endcase
			end
		end
	end

	// Holding the clock low only ever lengthens a low phase; the master
	// times its high phase from when it sees the line rise.
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			scl_oe_q <= 1'b0;
		end else if (!stretch_s || mode_q == M_IDLE || mode_q == M_SKIP) begin
			scl_oe_q <= 1'b0;
		end else if (scl_fall) begin
			scl_oe_q <= 1'b1; // RULE20
		end
	end

	assign link.s_sda_oe = sda_oe_q;
	assign link.s_scl_oe = scl_oe_q;

	// -----------------------------------------------------------------
	// Reference domain: byte hand-over and status
	// -----------------------------------------------------------------
	// The byte register in the link domain is steady for a whole packet
	// after the toggle, far longer than the three-flop crossing.
	logic tg_m, tg_s, tg_p, bz_m, bz_s, rx_valid_q, rx_gc_out_q;
	logic [7:0] rx_data_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			{tg_m, tg_s, tg_p} <= 3'h0;
			{bz_m, bz_s} <= 2'h0;
			rx_valid_q <= 1'b0;
			rx_gc_out_q <= 1'b0;
			rx_data_q <= 8'h00;
		end else begin
			{tg_m, tg_s, tg_p} <= {rx_tgl_q, tg_m, tg_s};
			{bz_m, bz_s} <= {busy_q, bz_m};
			rx_valid_q <= tg_s ^ tg_p;
			if (tg_s ^ tg_p) begin
				rx_data_q <= rx_q;
				rx_gc_out_q <= rx_gc_q;
			end
		end
	end

	assign rx_data = rx_data_q;
	assign rx_gc = rx_gc_out_q;
	assign rx_valid = rx_valid_q;
	assign bus_busy = bz_s;
endmodule

// >>> testbench/two_wire_sva.sv
// Purpose: Line-level checks on the two-wire link.
// Assumes: ref_clk samples both lines far faster than the bus clock.
// Notes: Bit position is rebuilt from the lines alone.
`timescale 1ns/100ps
module two_wire_sva (
	// Clocks and reset
	input wire logic ref_clk,
	input wire logic link_clk,
	input wire logic rstn,
	// Link lines
	input wire logic m_scl_oe,
	input wire logic m_sda_oe,
	input wire logic s_scl_oe,
	input wire logic s_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	// ------------------------------
	// Helper state
	// ------------------------------
	localparam int MIN_HALF = 150;
	logic scl_q, sda_q, addr_q;
	logic [3:0] pos_q;
	logic [7:0] hi_q, lo_q;
	wire start_w = scl && scl_q && sda_q && !sda;
	wire stop_w = scl && scl_q && !sda_q && sda;
	wire rise_w = scl && !scl_q;
	// A start clears the position, so a repeated start opens a fresh address packet.
	wire [3:0] pos_d = start_w ? 4'h0 : (rise_w ? (pos_q == 4'h9 ? 4'h1 : pos_q + 4'h1) : pos_q);
	wire addr_d = start_w | (addr_q & ~(!scl && scl_q && pos_q == 4'h9));
	// Counts saturate so an idle bus cannot wrap them back below the limit.
	wire [7:0] hi_d = !scl ? 8'h00 : hi_q + {7'h00, hi_q != 8'hff};
	wire [7:0] lo_d = scl ? 8'h00 : lo_q + {7'h00, lo_q != 8'hff};

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			{scl_q, sda_q, addr_q} <= 3'h6;
			pos_q <= 4'h0;
			{hi_q, lo_q} <= 16'h0000;
		end else begin
			{scl_q, sda_q, addr_q} <= {scl, sda, addr_d};
			pos_q <= pos_d;
			{hi_q, lo_q} <= {hi_d, lo_d};
		end
	end

	// ------------------------------
	// Properties
	// ------------------------------
	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	property p_slave_sda_hold;
		scl && $past(scl) |-> $stable(s_sda_oe);
	endproperty
	property p_framing_master;
		scl && $past(scl) && $changed(sda) |-> !s_sda_oe && !$past(s_sda_oe);
	endproperty
	property p_start_hold;
		start_w |-> scl [*8];
	endproperty
	property p_stop_idle;
		stop_w |-> (scl && sda && !m_scl_oe) [*8];
	endproperty
	property p_one_driver;
		scl && $past(scl) |-> !(m_sda_oe && s_sda_oe);
	endproperty
	property p_high_min;
		$fell(scl) |-> hi_q >= MIN_HALF;
	endproperty
	property p_low_min;
		$rose(scl) |-> lo_q >= MIN_HALF;
	endproperty
	property p_stretch_low;
		$rose(s_scl_oe) |-> !scl && !$past(scl);
	endproperty
	property p_ack_ninth;
		addr_q && scl && $past(scl) && s_sda_oe |-> pos_q == 4'h9;
	endproperty
	// The slave moves its data driver on its own clock, so it is also watched there.
	property p_slave_sda_low;
		@(posedge link_clk) $changed(s_sda_oe) |-> !scl;
	endproperty

	a_slave_sda_hold: assert property (p_slave_sda_hold)
		else $error("slave data moved while clock high");
	a_framing_master: assert property (p_framing_master)
		else $error("slave made a start or stop");
	a_start_hold: assert property (p_start_hold)
		else $error("clock fell too soon after start");
	a_stop_idle: assert property (p_stop_idle)
		else $error("bus taken right after stop");
	a_one_driver: assert property (p_one_driver)
		else $error("both ends drive data in one bit");
	a_high_min: assert property (p_high_min)
		else $error("clock high phase too short");
	a_low_min: assert property (p_low_min)
		else $error("clock low phase too short");
	a_stretch_low: assert property (p_stretch_low)
		else $error("slave pulled clock while high");
	a_ack_ninth: assert property (p_ack_ninth)
		else $error("address answer outside ninth bit");
	a_slave_sda_low: assert property (p_slave_sda_low)
		else $error("slave data moved on link clock while clock high");

	c_start: cover property (start_w);
	c_stop: cover property (stop_w);
	c_ack: cover property (addr_q && pos_q == 4'h9 && scl && s_sda_oe);
	c_stretch: cover property ($rose(s_scl_oe));
endmodule

// >>> testbench/testbench.sv
// Purpose: Self-checking bench: bus master end driving the slave end.
// Assumes: Commands keep to the master's ready and done handshake.
// Notes: link_clk runs free at 12 ns, out of phase with ref_clk.
`timescale 1ns/100ps
module testbench;
	// ------------------------------
	// Signals
	// ------------------------------
	logic ref_clk = 1'h0;
	logic link_clk = 1'h0;
	logic rstn = 1'h0;
	logic cmd_valid = 1'h0;
	two_wire_pkg::cmd_t cmd = two_wire_pkg::CMD_START;
	logic [7:0] wr_data = 8'h00;
	logic ack_send = 1'h0;
	logic [6:0] own_addr = 7'h35;
	logic gc_enable = 1'h1;
	logic ack_enable = 1'h1;
	logic [7:0] tx_data = 8'h96;
	logic stretch = 1'h0;
	logic cmd_ready, done, err, ack_rx, m_busy, s_busy, rx_gc, rx_valid, got_err, got_done;
	logic [7:0] rd_data, rx_data;
	logic [8:0] wire_sr = 9'h000;
	logic [8:0] rx_q[$];
	int failures = 0;
	int samples_checked = 0;
	time t0;

	always #4 ref_clk = ~ref_clk;
	initial begin
		#1.3;
		forever #6 link_clk = ~link_clk;
	end

	two_wire_link_if two_wire_link_if_i ();
	two_wire_bus_master two_wire_bus_master_i (.ref_clk(ref_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd),
		.wr_data(wr_data), .ack_send(ack_send), .cmd_ready(cmd_ready), .done(done), .err(err), .rd_data(rd_data),
		.ack_rx(ack_rx), .bus_busy(m_busy), .link(two_wire_link_if_i.master));
	two_wire_slave two_wire_slave_i (.ref_clk(ref_clk), .link_clk(link_clk), .rstn(rstn), .own_addr(own_addr),
		.gc_enable(gc_enable), .ack_enable(ack_enable), .tx_data(tx_data), .stretch(stretch), .rx_data(rx_data),
		.rx_gc(rx_gc), .rx_valid(rx_valid), .bus_busy(s_busy), .link(two_wire_link_if_i.slave));
	two_wire_sva two_wire_sva_i (.ref_clk(ref_clk), .link_clk(link_clk), .rstn(rstn),
		.m_scl_oe(two_wire_link_if_i.m_scl_oe), .m_sda_oe(two_wire_link_if_i.m_sda_oe),
		.s_scl_oe(two_wire_link_if_i.s_scl_oe), .s_sda_oe(two_wire_link_if_i.s_sda_oe),
		.scl(two_wire_link_if_i.scl), .sda(two_wire_link_if_i.sda));

	// The wire itself is watched so bit order is judged independently of either end.
	always @(posedge two_wire_link_if_i.scl) begin
		wire_sr <= {wire_sr[7:0], two_wire_link_if_i.sda};
	end
	always @(negedge ref_clk) begin
		if (rx_valid === 1'h1) begin
			rx_q.push_back({rx_gc, rx_data});
		end
	end

	// ------------------------------
	// Tasks
	// ------------------------------
	task automatic check_byte(input logic [8:0] got, input logic [8:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic run(input two_wire_pkg::cmd_t c, input logic [7:0] d, input logic a);
		int n;
		{got_err, got_done} = 2'h0;
		for (n = 0; n < 9000 && cmd_ready !== 1'h1; n++) @(negedge ref_clk);
		@(posedge ref_clk);
		cmd <= c;
		wr_data <= d;
		ack_send <= a;
		cmd_valid <= 1'h1;
		@(posedge ref_clk);
		cmd_valid <= 1'h0;
		// A refusal leaves ready high, so the first cycles are always watched for err.
		for (n = 0; n < 20000; n++) begin
			@(negedge ref_clk);
			got_err |= err === 1'h1;
			got_done |= done === 1'h1;
			if (n > 2 && (got_err || (c >= two_wire_pkg::CMD_WRITE ? got_done : cmd_ready === 1'h1))) break;
		end
		if (n == 20000) failures++;
	endtask

	task automatic wr(input logic [7:0] d, input logic ack);
		run(two_wire_pkg::CMD_WRITE, d, 1'h0);
		check_bit(ack_rx, ack);
		check_byte(wire_sr, {d, ~ack});
	endtask

	task automatic rd(input logic a, input logic [7:0] exp);
		run(two_wire_pkg::CMD_READ, 8'h00, a);
		check_byte({1'h0, rd_data}, {1'h0, exp});
		check_byte(wire_sr, {exp, ~a});
	endtask

	task automatic rx_next(input logic [8:0] exp);
		check_byte(rx_q.size() == 0 ? 'x : rx_q.pop_front(), exp);
	endtask

	task automatic probe(input logic [6:0] own, input logic gc, input logic [7:0] addr, input logic ack);
		@(posedge ref_clk);
		own_addr <= own;
		gc_enable <= gc;
		run(two_wire_pkg::CMD_START, 8'h00, 1'h0);
		wr(addr, ack);
		if (ack) begin
			wr(8'h5e, 1'h1);
			rx_next({1'h1, 8'h5e});
		end
		run(two_wire_pkg::CMD_STOP, 8'h00, 1'h0);
	endtask

	task automatic wrap_up();
		$display("Checked %0d values, %0d mismatches", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ------------------------------
	// Sequence
	// ------------------------------
	initial begin
		repeat (12) @(posedge ref_clk);
		rstn <= 1'h1;
		repeat (4) @(posedge ref_clk);
		run(two_wire_pkg::CMD_START, 8'h00, 1'h0);
		check_bit(s_busy, 1'h1);
		wr(8'h6a, 1'h1);
		wr(8'ha5, 1'h1);
		wr(8'h3c, 1'h1);
		rx_next({1'h0, 8'ha5});
		rx_next({1'h0, 8'h3c});
		run(two_wire_pkg::CMD_START, 8'h00, 1'h0);
		check_bit(s_busy & m_busy, 1'h1);
		wr(8'h6b, 1'h1);
		rd(1'h1, 8'h96);
		rd(1'h0, 8'h96);
		run(two_wire_pkg::CMD_STOP, 8'h00, 1'h0);
		repeat (8) @(posedge ref_clk);
		check_bit(s_busy | m_busy, 1'h0);
		probe(7'h35, 1'h1, 8'h24, 1'h0);
		probe(7'h7a, 1'h1, 8'hf4, 1'h0);
		probe(7'h35, 1'h1, 8'h00, 1'h1);
		probe(7'h35, 1'h0, 8'h00, 1'h0);
		@(posedge ref_clk);
		ack_enable <= 1'h0;
		probe(7'h35, 1'h1, 8'h6a, 1'h0);
		@(posedge ref_clk);
		ack_enable <= 1'h1;
		run(two_wire_pkg::CMD_STOP, 8'h00, 1'h0);
		check_bit(got_err, 1'h1);
		run(two_wire_pkg::CMD_START, 8'h00, 1'h0);
		run(two_wire_pkg::CMD_STOP, 8'h00, 1'h0);
		check_bit(got_err, 1'h1);
		run(two_wire_pkg::CMD_READ, 8'h00, 1'h0);
		check_bit(got_err, 1'h1);
		run(two_wire_pkg::CMD_WRITE, 8'h01, 1'h0);
		check_bit(got_err, 1'h1);
		wr(8'h6a, 1'h1);
		@(posedge ref_clk);
		stretch <= 1'h1;
		t0 = $time;
		fork
			wr(8'hc7, 1'h1);
			begin
				repeat (3000) @(posedge ref_clk);
				stretch <= 1'h0;
			end
		join
		check_bit(($time - t0) > 40000, 1'h1);
		rx_next({1'h0, 8'hc7});
		// A receiver that can take no more still stores the byte but refuses it on the line.
		@(posedge ref_clk);
		ack_enable <= 1'h0;
		wr(8'h81, 1'h0);
		rx_next({1'h0, 8'h81});
		@(posedge ref_clk);
		ack_enable <= 1'h1;
		run(two_wire_pkg::CMD_STOP, 8'h00, 1'h0);
		check_bit(got_err, 1'h0);
		check_bit(rx_q.size() == 0, 1'h1);
		wrap_up();
	end

	initial begin
		repeat (90000) @(posedge ref_clk);
		failures++;
		wrap_up();
	end
endmodule
